// ---- fsp_pkg.sv ----
// package of constants for the serial flash status, protect and identity block
// assumes a 20 MHz system clock and an spi mode 0/3 master on the link
package fsp_pkg;

    // ****************************************************************
    // instruction opcodes
    // ****************************************************************
    localparam logic [7:0] ARM_CMD          = 8'h06;
    localparam logic [7:0] DISARM_CMD       = 8'h04;
    localparam logic [7:0] IDENT_READ_CMD   = 8'h9f;
    localparam logic [7:0] STATUS_READ_CMD  = 8'h05;
    localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
    localparam logic [7:0] PAGE_BURN_CMD    = 8'h02;
    localparam logic [7:0] BLOCK_WIPE_CMD   = 8'hd8;
    localparam logic [7:0] FULL_WIPE_CMD    = 8'hc7;

    // ****************************************************************
    // status byte layout and reset values
    // ****************************************************************
    localparam int          BUSY_POS        = 0;
    localparam int          ARM_POS         = 1;
    localparam int          GUARD_LSB       = 2;
    localparam int          GUARD_MSB       = 4;
    localparam int          LOCK_POS        = 7;
    localparam logic [2:0]  GUARD_RESET     = 3'h0;
    localparam logic        LOCK_RESET      = 1'b0;

    // ****************************************************************
    // frame lengths in whole bytes after the opcode byte is counted
    // ****************************************************************
    localparam logic [2:0]  SHORT_BYTES     = 3'h1;
    localparam logic [2:0]  STATUS_WR_BYTES = 3'h2;
    localparam logic [2:0]  BLOCK_WIPE_BYTES = 3'h4;
    localparam logic [2:0]  PAGE_BURN_BYTES = 3'h5;

    // ****************************************************************
    // identity readout, values arbitrary
    // ****************************************************************
    localparam logic [7:0]  MAKER_CODE      = 8'h5a;  // arbitrary value
    localparam logic [7:0]  MEMORY_TYPE     = 8'ha5;  // arbitrary value
    localparam logic [7:0]  CAPACITY_CODE   = 8'h3c;  // arbitrary value

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int unsigned CLOCK_PERIOD_NS      = 50;
    localparam int unsigned STATUS_WRITE_TIME_US = 5000;
    localparam int unsigned PAGE_BURN_TIME_US    = 1000;
    localparam int unsigned BLOCK_WIPE_TIME_US   = 100000;
    localparam int unsigned FULL_WIPE_TIME_US    = 1000000;
    localparam int unsigned STATUS_WRITE_CYCLES  = STATUS_WRITE_TIME_US * 1000 / CLOCK_PERIOD_NS;
    localparam int unsigned PAGE_BURN_CYCLES     = PAGE_BURN_TIME_US * 1000 / CLOCK_PERIOD_NS;
    localparam int unsigned BLOCK_WIPE_CYCLES    = BLOCK_WIPE_TIME_US * 1000 / CLOCK_PERIOD_NS;
    localparam int unsigned FULL_WIPE_CYCLES     = FULL_WIPE_TIME_US * 1000 / CLOCK_PERIOD_NS;

    // ****************************************************************
    // self-timed cycle in progress
    // ****************************************************************
    typedef enum logic [2:0] {
        CYC_IDLE         = 3'b000,
        CYC_STATUS_WRITE = 3'b001,
        CYC_PAGE_BURN    = 3'b010,
        CYC_BLOCK_WIPE   = 3'b011,
        CYC_FULL_WIPE    = 3'b100
    } fsp_cycle_type;

endpackage

// ---- fsp_status_protect.sv ----
// status, arm latch, area guard, status lock and identity logic of a serial flash
// assumes: sclk is the link clock, stopped while sel_b is high; dout and
// dout_oe_b are resolved onto the shared line by the surroundings
//
// Notes on behaviour
// RQ1: disarm is opcode alone, then clears arm latch
// RQ2: arm latch cleared at reset and completions
// RQ3: identity is maker, type, capacity, falling edges
// RQ4: identity ignored while program or erase runs
// RQ5: deselect ends readout and releases the output
// RQ6: after deselect wait for a new frame
// RQ7: status read always allowed, repeats continuously
// RQ8: master polls busy flag before new instructions
// RQ9: busy flag high during any self-timed cycle
// RQ10: arm latch shown; zero refuses writes and erases
// RQ11: area guards written by status write only
// RQ12: full wipe only when all guards zero
// RQ13: lock bit with pin low refuses status write
// RQ14: master arms, then sends status write and byte
// RQ15: bits six and five read zero, unchanged
// RQ16: status write needs exactly its data byte
// RQ17: status write busy, then clears busy and arm
// RQ18: lock bit zero: writable whenever armed
// RQ19: lock bit set, pin high: writable when armed
// RQ20: hard lock entered in either order
// RQ21: hard lock left only by pin high
// RQ22: all bytes move most significant bit first
// RQ23: short instructions need whole bytes only
// RQ24: master arms before every write or erase
// RQ25: status byte layout busy, arm, guards, lock
// RQ26: opcodes 06, 04, 9f, 05, 01
`timescale 1ns/100ps
module fsp_status_protect
#(
    parameter int unsigned STATUS_WRITE_CYCLES = fsp_pkg::STATUS_WRITE_CYCLES,
    parameter int unsigned PAGE_BURN_CYCLES    = fsp_pkg::PAGE_BURN_CYCLES,
    parameter int unsigned BLOCK_WIPE_CYCLES   = fsp_pkg::BLOCK_WIPE_CYCLES,
    parameter int unsigned FULL_WIPE_CYCLES    = fsp_pkg::FULL_WIPE_CYCLES
)
(
    input  wire logic clock,
    input  wire logic rst_b,
    input  wire logic ce,
    input  wire logic sel_b,
    input  wire logic sclk,
    input  wire logic din,
    output logic      dout,
    output logic      dout_oe_b,
    input  wire logic wp_b,
    output logic      hard_lock_state,
    output logic      area_guard_state
);
    import fsp_pkg::*;

    // ****************************************************************
    // parameter checks
    // ****************************************************************
    if (STATUS_WRITE_CYCLES < 1 || PAGE_BURN_CYCLES < 1 ||
        BLOCK_WIPE_CYCLES < 1 || FULL_WIPE_CYCLES < 1)
    begin : g_bad_cycles
        $error("self-timed cycle counts must be at least one");
    end

    // ****************************************************************
    // link domain: shift in, count, capture opcode
    // ****************************************************************
    logic        frame_rst_b;
    logic        in_frame;
    logic [2:0]  bit_pos;
    logic [2:0]  byte_cnt;
    logic [15:0] shift_in;
    logic [7:0]  opcode;
    logic        frame_tog;
    logic [2:0]  next_bit_pos;
    logic [2:0]  next_byte_cnt;
    logic [7:0]  status_meta;
    logic [7:0]  status_sync;
    logic [7:0]  out_shift;
    logic        out_on;
    logic        load_byte;
    logic        emit;
    logic [7:0]  next_byte;
    logic [7:0]  ident_byte;
    logic [7:0]  status_byte;

    // deselect clears the frame marker, the output shifter and the output enable, so counts survive until read
    assign frame_rst_b = rst_b & ~sel_b;

    // bit and byte position; byte count saturates so long frames stay legal
    assign next_bit_pos  = in_frame ? bit_pos + 3'h1 : 3'h1;
    assign next_byte_cnt = !in_frame ? 3'h0 :
                           (bit_pos == 3'h7 && byte_cnt != 3'h7) ? byte_cnt + 3'h1 :
                           byte_cnt;

    // frame marker, set by the first edge after selection
    always_ff @(posedge sclk or negedge frame_rst_b)
    begin
        if (!frame_rst_b)
            in_frame <= 1'b0;
        else
            in_frame <= 1'b1;
    end

    // input shifting, msb first, data on rising edges
    always_ff @(posedge sclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            bit_pos   <= 3'h0;
            byte_cnt  <= 3'h0;
            shift_in  <= 16'h0000;
            opcode    <= 8'h00;
            frame_tog <= 1'b0;
        end
        else
        begin
            bit_pos  <= next_bit_pos;
            byte_cnt <= next_byte_cnt;
            shift_in <= {shift_in[14:0], din};                 // RQ22
            if (in_frame && bit_pos == 3'h7 && byte_cnt == 3'h0)
                opcode <= {shift_in[6:0], din};
            if (!in_frame)
                frame_tog <= ~frame_tog;                       // RQ6
        end
    end

    // status byte crosses bit by bit as levels; it settles long before use
    always_ff @(posedge sclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            status_meta <= 8'h00;
            status_sync <= 8'h00;
        end
        else
        begin
            status_meta <= status_byte;
            status_sync <= status_meta;
        end
    end

    // ****************************************************************
    // link domain: output on falling edges
    // ****************************************************************
    assign load_byte  = in_frame && bit_pos == 3'h0 && byte_cnt != 3'h0;
    assign ident_byte = (byte_cnt == 3'h1) ? MAKER_CODE :
                        (byte_cnt == 3'h2) ? MEMORY_TYPE :
                        (byte_cnt == 3'h3) ? CAPACITY_CODE : 8'h00;     // RQ3
    // busy hides the identity opcode entirely, status read is always served
    assign emit       = opcode == STATUS_READ_CMD ||
                        (opcode == IDENT_READ_CMD && !status_sync[BUSY_POS]); // RQ4 RQ7
    assign next_byte  = (opcode == STATUS_READ_CMD) ? status_sync : ident_byte;

    // deselect releases the line at once, without waiting for a clock
    always_ff @(negedge sclk or negedge frame_rst_b)
    begin
        if (!frame_rst_b)
        begin
            out_shift <= 8'h00;                                // RQ5
            out_on    <= 1'b0;
        end
        else if (load_byte)
        begin
            out_shift <= next_byte;                            // RQ7
            out_on    <= emit;
        end
        else
            out_shift <= {out_shift[6:0], 1'b0};               // RQ3
    end

    assign dout      = out_shift[7];
    assign dout_oe_b = ~out_on;

    // ****************************************************************
    // system domain: synchronisers and frame end
    // ****************************************************************
    logic          sel_meta;
    logic          sel_sync;
    logic          sel_last;
    logic          tog_meta;
    logic          tog_sync;
    logic          tog_seen;
    logic          wp_meta;
    logic          wp_sync;
    logic          frame_end;
    logic          frame_new;

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sel_meta <= 1'b1;
            sel_sync <= 1'b1;
            sel_last <= 1'b1;
            tog_meta <= 1'b0;
            tog_sync <= 1'b0;
            tog_seen <= 1'b0;
            wp_meta  <= 1'b1;
            wp_sync  <= 1'b1;
        end
        else if (ce)
        begin
            sel_meta <= sel_b;
            sel_sync <= sel_meta;
            sel_last <= sel_sync;
            tog_meta <= frame_tog;
            tog_sync <= tog_meta;
            wp_meta  <= wp_b;
            wp_sync  <= wp_meta;
            if (frame_end)
                tog_seen <= tog_sync;
        end
    end

    // a deselect without clocks carries no instruction
    assign frame_end = sel_sync & ~sel_last;
    assign frame_new = tog_sync != tog_seen;

    // ****************************************************************
    // system domain: protection state and decode
    // ****************************************************************
    fsp_cycle_type cycle;
    logic          arm_latch;
    logic [2:0]    area_guard;
    logic          status_lock_bit;
    logic [7:0]    wr_data;
    logic [31:0]   timer;
    logic          busy_flag;
    logic          taken;
    logic          whole;
    logic          guards_clear;
    logic          arm_ok;
    logic          disarm_ok;
    logic          status_write_cmd_ok;
    logic          burn_ok;
    logic          bwipe_ok;
    logic          fwipe_ok;
    logic          cycle_done;
    logic [31:0]   load_count;

    assign busy_flag        = cycle != CYC_IDLE;                      // RQ9
    assign hard_lock_state  = status_lock_bit & ~wp_sync;             // RQ13 RQ20 RQ21
    assign area_guard_state = |area_guard;
    assign status_byte      = {status_lock_bit, 2'b00, area_guard,
                               arm_latch, busy_flag};                 // RQ15 RQ25
    // opcode, counts and data are quiet here: the link clock stopped at deselect
    assign taken        = frame_end && frame_new && !busy_flag;       // RQ8
    assign whole        = bit_pos == 3'h0;                            // RQ23
    assign guards_clear = area_guard == GUARD_RESET;
    assign arm_ok    = taken && whole && byte_cnt == SHORT_BYTES && opcode == ARM_CMD;  // RQ26
    assign disarm_ok = taken && whole && byte_cnt == SHORT_BYTES
                       && opcode == DISARM_CMD;                       // RQ1
    assign status_write_cmd_ok   = taken && whole && byte_cnt == STATUS_WR_BYTES
                       && opcode == STATUS_WRITE_CMD && arm_latch
                       && !hard_lock_state;                           // RQ10 RQ13 RQ16 RQ18 RQ19
    assign burn_ok   = taken && whole && byte_cnt >= PAGE_BURN_BYTES
                       && opcode == PAGE_BURN_CMD && arm_latch && guards_clear; // RQ11
    assign bwipe_ok  = taken && whole && byte_cnt == BLOCK_WIPE_BYTES
                       && opcode == BLOCK_WIPE_CMD && arm_latch && guards_clear; // RQ11
    assign fwipe_ok  = taken && whole && byte_cnt == SHORT_BYTES
                       && opcode == FULL_WIPE_CMD && arm_latch && guards_clear; // RQ12
    assign cycle_done = busy_flag && timer == 32'h0;
    assign load_count = status_write_cmd_ok  ? 32'(STATUS_WRITE_CYCLES - 1) :
                        burn_ok  ? 32'(PAGE_BURN_CYCLES - 1) :
                        bwipe_ok ? 32'(BLOCK_WIPE_CYCLES - 1) :
                        32'(FULL_WIPE_CYCLES - 1);

    // guard and lock bits reset to their delivery state; a real part keeps them
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cycle           <= CYC_IDLE;
            arm_latch       <= 1'b0;                                  // RQ2
            area_guard      <= GUARD_RESET;
            status_lock_bit <= LOCK_RESET;
            wr_data         <= 8'h00;
            timer           <= 32'h0;
        end
        else if (ce)
        begin
            if (cycle_done)
            begin
                cycle     <= CYC_IDLE;
                arm_latch <= 1'b0;                                    // RQ2 RQ17
                if (cycle == CYC_STATUS_WRITE)
                begin
                    area_guard      <= wr_data[GUARD_MSB:GUARD_LSB];  // RQ11
                    status_lock_bit <= wr_data[LOCK_POS];
                end
            end
            else if (busy_flag)
                timer <= timer - 32'h1;
            else if (arm_ok)
                arm_latch <= 1'b1;
            else if (disarm_ok)
                arm_latch <= 1'b0;                                    // RQ1 RQ2
            else if (status_write_cmd_ok || burn_ok || bwipe_ok || fwipe_ok)
            begin
                timer   <= load_count;                                // RQ17
                wr_data <= shift_in[7:0];
                cycle   <= status_write_cmd_ok  ? CYC_STATUS_WRITE :
                           burn_ok  ? CYC_PAGE_BURN :
                           bwipe_ok ? CYC_BLOCK_WIPE : CYC_FULL_WIPE;
            end
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    sequence s_status_write_cmd_start;
        ce && status_write_cmd_ok ##1 busy_flag;
    endsequence
    property p_status_write_cmd_busy;
        @(posedge clock) disable iff (!rst_b)
        s_status_write_cmd_start |=> busy_flag && cycle == CYC_STATUS_WRITE;
    endproperty
    a_status_write_cmd_busy: assert property (p_status_write_cmd_busy) else $error("status write did not go busy"); // RQ17
    property p_disarm_clears;
        @(posedge clock) disable iff (!rst_b)
        ce && disarm_ok |=> !arm_latch;
    endproperty
    a_disarm_clears: assert property (p_disarm_clears) else $error("disarm left latch set"); // RQ1
    property p_arm_sets;
        @(posedge clock) disable iff (!rst_b)
        ce && arm_ok |=> arm_latch && !busy_flag;
    endproperty
    a_arm_sets: assert property (p_arm_sets) else $error("arm did not set latch"); // RQ10
    property p_locked_refuses;
        @(posedge clock) disable iff (!rst_b)
        ce && taken && opcode == STATUS_WRITE_CMD && hard_lock_state |=> !busy_flag;
    endproperty
    a_locked_refuses: assert property (p_locked_refuses) else $error("locked write ran"); // RQ13
    property p_full_wipe_guarded;
        @(posedge clock) disable iff (!rst_b)
        ce && taken && opcode == FULL_WIPE_CMD && !guards_clear |=> !busy_flag;
    endproperty
    a_full_wipe_guarded: assert property (p_full_wipe_guarded) else $error("guard missed"); // RQ12
    property p_end_clears_arm;
        @(posedge clock) disable iff (!rst_b)
        $fell(busy_flag) |-> !arm_latch;
    endproperty
    a_end_clears_arm: assert property (p_end_clears_arm) else $error("arm kept at end"); // RQ2
    property p_lock_holds_bits;
        @(posedge clock) disable iff (!rst_b)
        hard_lock_state && !busy_flag |=> $stable(area_guard) && $stable(status_lock_bit);
    endproperty
    a_lock_holds_bits: assert property (p_lock_holds_bits) else $error("lock bits moved"); // RQ13
    property p_unarmed_refuses;
        @(posedge clock) disable iff (!rst_b)
        ce && taken && !arm_latch |=> !busy_flag;
    endproperty
    a_unarmed_refuses: assert property (p_unarmed_refuses) else $error("unarmed run"); // RQ10
    property p_line_released;
        @(posedge clock) disable iff (!rst_b)
        sel_sync |-> dout_oe_b;
    endproperty
    a_line_released: assert property (p_line_released) else $error("driven while idle"); // RQ5
    property p_status_write_cmd_lands;
        @(posedge clock) disable iff (!rst_b)
        ce && cycle_done && cycle == CYC_STATUS_WRITE
        |=> area_guard == $past(wr_data[GUARD_MSB:GUARD_LSB]);
    endproperty
    a_status_write_cmd_lands: assert property (p_status_write_cmd_lands) else $error("status write not stored"); // RQ11
endmodule

// ---- fsp_spi_master.sv ----
// spi master model for the link of the status, protect and identity block
// assumes mode 0: link clock idles low and stands still between frames
`timescale 1ns/100ps
module fsp_spi_master
(
    output logic      sel_b,
    output logic      sclk,
    input  wire logic dout,
    input  wire logic dout_oe_b,
    output logic      din
);
    // ****************************************************************
    // frame driver
    // ****************************************************************
    localparam int HALF_NS = 16;  // 32 ns link period

    // idle levels at time zero
    initial
    begin
        sel_b = 1'b1;
        sclk  = 1'b0;
        din   = 1'b1;
    end

    // one frame, msb first; answer sampled on each rising link edge
    task automatic frame(input logic [39:0] tx, input int nbits, output logic [39:0] rx,
                         output logic oe_seen);
        rx = '0;
        oe_seen = 1'b0;
        #2 sel_b = 1'b0;
        for (int i = nbits - 1; i >= 0; i--)
        begin
            din = tx[i];
            #HALF_NS sclk = 1'b1;
            // a released line reads as the inverse of what was last driven
            rx = {rx[38:0], dout_oe_b ? ~dout : dout};
            oe_seen = oe_seen | ~dout_oe_b;
            #HALF_NS sclk = 1'b0;
        end
        #HALF_NS sel_b = 1'b1;
        din = ~din;  // a released line must not keep showing its last bit
    endtask
endmodule

// ---- tb_serial_flash_status_protect_id.sv ----
// self-checking bench for the status, protect and identity block
// assumes the spi master model drives the link; short self-timed cycles
`timescale 1ns/100ps
module tb_serial_flash_status_protect_id;
    import fsp_pkg::*;
    // ****************************************************************
    // signals and instances
    // ****************************************************************
    localparam int unsigned CYC = 100;  // shortened self-timed cycles
    logic        clock, rst_b, ce, wp_b, sel_b, sclk, din, dout, dout_oe_b;
    logic        hard_lock_state, area_guard_state, oe, armed, ok;
    logic [39:0] rx;
    logic [7:0]  st, nv, d;
    int          fails, num_checks;
    logic [39:0] wcmd [3] = '{40'hc7, 40'hd8000000, 40'h0200000000};
    int          wlen [3] = '{8, 32, 40};

    fsp_status_protect #(.STATUS_WRITE_CYCLES(CYC), .PAGE_BURN_CYCLES(CYC),
        .BLOCK_WIPE_CYCLES(CYC), .FULL_WIPE_CYCLES(CYC)) i_fsp_status_protect (
        .clock(clock), .rst_b(rst_b), .ce(ce), .sel_b(sel_b), .sclk(sclk), .din(din),
        .dout(dout), .dout_oe_b(dout_oe_b), .wp_b(wp_b), .hard_lock_state(hard_lock_state),
        .area_guard_state(area_guard_state));
    fsp_spi_master i_fsp_spi_master (.sel_b(sel_b), .sclk(sclk), .dout(dout),
        .dout_oe_b(dout_oe_b), .din(din));

    // system clock, 50 ns period
    always #25 clock = ~clock;

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("checks=%0d mismatches=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // frame, then let chip select stand high long enough for decode
    task automatic xfer(input logic [39:0] tx, input int n);
        i_fsp_spi_master.frame(tx, n, rx, oe);
        repeat (8) @(posedge clock);
    endtask

    task automatic rd_status();
        xfer(40'h0500, 16);
        st = rx[7:0];
    endtask

    // bounded busy poll; a hang ends the run
    task automatic wait_idle();
        for (int k = 0; k < 40; k++)
        begin
            rd_status();
            if (st[BUSY_POS] === 1'b0)
                return;
        end
        fails++;
        close_out();
    endtask

    task automatic set_wp(input logic v);
        @(posedge clock);
        #2 wp_b = v;
        repeat (4) @(posedge clock);  // two-flop sync plus margin
    endtask

    // expected status after a write attempt, arm latch cleared beforehand
    function automatic logic [7:0] nv_after(input logic [7:0] cur, input logic [7:0] dat,
                                            input logic arm, input logic wp);
        if (arm && !(cur[LOCK_POS] && !wp))
            return {dat[7], 2'b00, dat[4:2], 2'b00};
        return cur | {6'h00, arm, 1'b0};
    endfunction

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        clock = 1'b0;
        rst_b = 1'b0;
        ce = 1'b1;
        wp_b = 1'b1;
        fails = 0;
        num_checks = 0;
        nv = 8'h00;
        void'($urandom(75118));
        repeat (8) @(posedge clock);
        #2 rst_b = 1'b1;
        repeat (4) @(posedge clock);
        rd_status();
        chk(st, 8'h00);
        chk({hard_lock_state, area_guard_state}, 2'b00);
        // identity in full, then cut short in mid-byte
        xfer(40'h9f000000, 32);
        chk(rx[23:0], {MAKER_CODE, MEMORY_TYPE, CAPACITY_CODE});
        chk(oe, 1'b1);
        xfer(40'h13e0, 13);
        chk(rx[4:0], MAKER_CODE[7:3]);
        chk(dout_oe_b, 1'b1);
        // arm, repeated status, disarm one bit too long, real disarm
        xfer(40'h06, 8);
        xfer(40'h050000, 24);
        chk(rx[15:0], 16'h0202);
        xfer(40'h08, 9);
        rd_status();
        chk(st, 8'h02);
        xfer(40'h011c00, 24);
        rd_status();
        chk(st, 8'h02);
        xfer(40'h04, 8);
        rd_status();
        chk(st, 8'h00);
        // random status writes against random pin level and arming
        for (int it = 0; it < 14; it++)
        begin
            d = 8'($urandom);
            armed = 1'($urandom);
            set_wp(1'($urandom));
            chk(hard_lock_state, nv[LOCK_POS] & ~wp_b);
            ok = armed & ~(nv[LOCK_POS] & ~wp_b);
            if (armed)
                xfer(40'h06, 8);
            xfer({24'h0, STATUS_WRITE_CMD, d}, 16);
            rd_status();
            chk(st[BUSY_POS], ok);
            wait_idle();
            nv = nv_after(nv, d, armed, wp_b);
            chk(st, nv);
            chk(area_guard_state, |nv[4:2]);
            xfer(40'h04, 8);
            nv[ARM_POS] = 1'b0;
        end
        // hand-made lock: lock bit first, then pin low, then pin high again
        set_wp(1'b1);
        xfer(40'h06, 8);
        xfer(40'h0180, 16);
        wait_idle();
        chk(st, 8'h80);
        set_wp(1'b0);
        xfer(40'h06, 8);
        xfer(40'h0100, 16);
        rd_status();
        chk({hard_lock_state, st}, 9'h182);
        set_wp(1'b1);
        chk(hard_lock_state, 1'b0);
        xfer(40'h04, 8);
        // wipes and burn with guards set, then clear; ce low must freeze the timer
        set_wp(1'b1);
        for (int j = 0; j < 3; j++)
        begin
            for (int g = 1; g >= 0; g--)
            begin
                xfer(40'h06, 8);
                xfer({32'h01, (g == 1) ? 8'h10 : 8'h00}, 16);
                wait_idle();
                xfer(40'h06, 8);
                xfer(wcmd[j], wlen[j]);
                rd_status();
                chk(st[1:0], (g == 1) ? 2'b10 : 2'b11);
                if (g == 0)
                begin
                    xfer(40'h9f000000, 32);
                    chk(oe, 1'b0);
                    // a running timer would have expired during this pause
                    #2 ce = 1'b0;
                    repeat (200) @(posedge clock);
                    #2 ce = 1'b1;
                    rd_status();
                    chk(st[BUSY_POS], 1'b1);
                end
                wait_idle();
                chk(st, (g == 1) ? 8'h12 : 8'h00);
                xfer(40'h04, 8);
            end
        end
        close_out();
    end
endmodule
